//--- include/hrw_pkg.sv
// Purpose: Constants for the hub remote wake indicator block
// Assumes: pclk at 20 MHz
// Notes: Register offsets are byte addresses on APB
package hrw_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   // Timing figures in their own units
   localparam int unsigned FILTER_US = 100;
   localparam int unsigned WAKE_PULSE_MS = 14;
   localparam int unsigned FILTER_CYC = (CLK_HZ / 1000000) * FILTER_US;
   localparam int unsigned WAKE_PULSE_CYC = (CLK_HZ / 1000) * WAKE_PULSE_MS;
   localparam int unsigned CNT_W = 24;
   // Register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_RESUME_TIME = 8'h08;
   localparam logic [7:0] ADDR_WAKE_PORTS = 8'h0C;
   // Control field positions
   localparam int unsigned CTRL_MOD_RESUME = 0;
   localparam int unsigned CTRL_REMOTE_WAKE_EN = 1;
   localparam int unsigned CTRL_BC_EN = 2;
   localparam int unsigned CTRL_SUSPEND = 3;
   localparam int unsigned CTRL_HIGH_SPEED = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [CNT_W-1:0] RESUME_TIME_RESET = 24'h04_4AA0;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_PULSE = 3'b010,
      ST_FINISH = 3'b100
   } hrw_state_e;
endpackage : hrw_pkg

//--- hw/hrw_wake_indicator.sv
// Purpose: Upstream suspend/wake indication logic of a hub
// Assumes: Inputs synchronous to pclk; APB register access
// Notes: Mode select is loaded at reset release only
//
// Operation
// - Select bit 0 gives normal resume, 1 gives modified resume
// - Select bit loaded only at reset, never changed at run time
// - Host power high asserts D+ pull-up and enables normal operation
// - Wake indicator shows active or suspended state in both modes
// - Normal mode, power low: drop pull-up; without charging reset hub, ports off
// - Normal mode drives K upstream when protocol requires; the code blocks it during the indicator pulse in both modes
// - Modified mode drives K up and down, acts as controlling hub
// - Modified mode, power low: drop pull-up, keep ports powered, keep detecting
// - Resume event with wake enabled and status change drives indicator resume time
// - Disconnect, connect and device wake request are remote wake events
// - Downstream resume events filtered for about 100 us
// - Modified mode downstream wake: no upstream K, pulse indicator 14 ms
// - Controlling hub resumes only ports that signalled wake
// - Indicator pulse fires once per wake event, no repeats
// - Host K within 14 ms ends controlling role, resume other ports
// - No host K within 14 ms: stop K and end resume with EOP
// - Speed LED active high for strap 0, active low for strap 1
// - Speed LED asserted at high speed, negated at full speed
// - Strap pin sampled at reset release, held, selects config method
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module hrw_wake_indicator
   import hrw_pkg::*;
#(
   parameter int unsigned PORTS = 3,
   parameter int unsigned FILTER_CYCLES = FILTER_CYC,
   parameter int unsigned PULSE_CYCLES = WAKE_PULSE_CYC
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Boot configuration
   input wire logic cfg_mod_resume,
   input wire logic config_method_strap_bit1,
   // Upstream side
   input wire logic host_power_sense,
   input wire logic host_k_detect,
   input wire logic proto_k_request,
   output logic dp_pullup_en,
   output logic upstream_k_drive,
   output logic usb_func_en,
   output logic hub_logic_reset,
   output logic wake_indicator,
   // Downstream side
   input wire logic [PORTS-1:0] ds_connect_evt,
   input wire logic [PORTS-1:0] ds_disconnect_evt,
   input wire logic [PORTS-1:0] ds_wake_req,
   output logic [PORTS-1:0] ds_port_power_en,
   output logic [PORTS-1:0] ds_resume_drive,
   output logic ds_eop_request,
   // Status
   output logic config_method_sel,
   output logic speed_led_out,
   output logic speed_led_oe
);

////////////////////////////////////////////////////////////////////////
   logic mod_resume_reg;
   logic strap_reg;
   logic strap_taken_reg;
   logic [31:0] ctrl_reg;
   logic [CNT_W-1:0] resume_time_reg;
   logic [PORTS-1:0] wake_ports_reg;
   logic [PORTS-1:0] wake_ports_next;
   logic [CNT_W-1:0] filt_cnt_reg;
   logic [CNT_W-1:0] pulse_cnt_reg;
   logic [CNT_W-1:0] pulse_cnt_next;
   logic [PORTS-1:0] pend_reg;
   hrw_state_e state_reg;
   hrw_state_e state_next;
   logic [31:0] prdata_next;

////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire bus_wr = psel && penable && pwrite;
   wire sel_ctrl = (paddr == ADDR_CTRL);
   wire sel_status = (paddr == ADDR_STATUS);
   wire sel_rtime = (paddr == ADDR_RESUME_TIME);
   wire sel_ports = (paddr == ADDR_WAKE_PORTS);
   wire mapped = sel_ctrl || sel_status || sel_rtime || sel_ports;
   wire rw_en = ctrl_reg[CTRL_REMOTE_WAKE_EN];
   wire bc_en = ctrl_reg[CTRL_BC_EN];
   wire suspended = ctrl_reg[CTRL_SUSPEND];
   wire high_speed = ctrl_reg[CTRL_HIGH_SPEED];
   wire host_on = host_power_sense;
   wire pulsing = (state_reg != ST_IDLE) && (state_reg == ST_PULSE);

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Event sources per port
   wire [PORTS-1:0] raw_evt = ds_connect_evt | ds_disconnect_evt | ds_wake_req;
   wire any_raw = |raw_evt;
   wire filt_done = (filt_cnt_reg == CNT_W'(FILTER_CYCLES));
   wire wake_fire = filt_done && rw_en && (state_reg == ST_IDLE);
   // Count starts at zero, so the last held cycle is one short of the length
   wire pulse_len_end = mod_resume_reg ? (pulse_cnt_reg == CNT_W'(PULSE_CYCLES - 1))
                                       : (pulse_cnt_reg == resume_time_reg - CNT_W'(1));
   wire host_took_over = (state_reg == ST_PULSE) && host_on && host_k_detect;

////////////////////////////////////////////////////////////////////////
   // Boot mode and strap, caught once after release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mod_resume_reg <= 1'b0;
         strap_reg <= 1'b0;
         strap_taken_reg <= 1'b0;
      end
      else if (!strap_taken_reg)
      begin
         mod_resume_reg <= cfg_mod_resume;
         strap_reg <= config_method_strap_bit1;
         strap_taken_reg <= 1'b1;
      end
   end

   // Software registers; CTRL mode bit is stored as written, the mode itself comes from cfg_mod_resume
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= CTRL_RESET;
         resume_time_reg <= RESUME_TIME_RESET;
      end
      else if (bus_wr && sel_ctrl)
         ctrl_reg <= pwdata;
      else if (bus_wr && sel_rtime)
         resume_time_reg <= pwdata[CNT_W-1:0];
   end

   // Filter: event must stand the whole window
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         filt_cnt_reg <= '0;
      else if (!any_raw || filt_done)
         filt_cnt_reg <= '0;
      else
         filt_cnt_reg <= filt_cnt_reg + CNT_W'(1);
   end

////////////////////////////////////////////////////////////////////////
   // Sequence of one wake pulse
   always_comb
   begin
      state_next = state_reg;
      pulse_cnt_next = pulse_cnt_reg + CNT_W'(1);
      wake_ports_next = wake_ports_reg;
      unique case (state_reg)
         ST_IDLE:
         begin
            pulse_cnt_next = '0;
            if (wake_fire)
            begin
               state_next = ST_PULSE;
               wake_ports_next = pend_reg | raw_evt;
            end
         end
         ST_PULSE:
         begin
            if (host_took_over)
            begin
               state_next = ST_IDLE;
               wake_ports_next = '0;
            end
            else if (pulse_len_end)
               state_next = ST_FINISH;
         end
         ST_FINISH:
         begin
            state_next = ST_IDLE;
            wake_ports_next = '0;
         end
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_IDLE;
         pulse_cnt_reg <= '0;
         wake_ports_reg <= '0;
         pend_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         pulse_cnt_reg <= pulse_cnt_next;
         wake_ports_reg <= wake_ports_next;
         pend_reg <= (state_reg == ST_IDLE) && !wake_fire && any_raw ? (pend_reg | raw_evt) : '0;
      end
   end

////////////////////////////////////////////////////////////////////////
   // Link outputs, all registered
   wire normal_reset = !mod_resume_reg && !host_on && !bc_en;
   wire k_allowed = host_on && proto_k_request && !pulsing;
   wire [PORTS-1:0] ds_resume_next = host_took_over ? ~wake_ports_reg
                                   : (mod_resume_reg && pulsing ? wake_ports_reg : '0);
   wire speed_level = high_speed && host_on;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dp_pullup_en <= 1'b0;
         usb_func_en <= 1'b0;
         hub_logic_reset <= 1'b0;
         upstream_k_drive <= 1'b0;
         ds_port_power_en <= '0;
         ds_resume_drive <= '0;
         ds_eop_request <= 1'b0;
         wake_indicator <= 1'b0;
         speed_led_out <= 1'b0;
      end
      else
      begin
         dp_pullup_en <= host_on;
         usb_func_en <= host_on;
         hub_logic_reset <= normal_reset;
         upstream_k_drive <= k_allowed;
         ds_port_power_en <= normal_reset ? '0 : {PORTS{1'b1}};
         ds_resume_drive <= ds_resume_next;
         ds_eop_request <= (state_reg == ST_FINISH) && mod_resume_reg;
         wake_indicator <= (state_next == ST_PULSE) || (suspended && state_next != ST_FINISH);
         speed_led_out <= speed_level ^ strap_reg;
      end
   end

   assign speed_led_oe = strap_taken_reg;
   assign config_method_sel = strap_reg;

////////////////////////////////////////////////////////////////////////
   // Read mux
   assign prdata_next = sel_ctrl ? ctrl_reg
                      : sel_status ? {24'h00_0000, 1'b0, state_reg, strap_reg, mod_resume_reg, host_on, pulsing}
                      : sel_rtime ? {8'h00, resume_time_reg}
                      : sel_ports ? 32'(wake_ports_reg)
                      : UNMAPPED_READ;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (psel && !penable && !pwrite)
         prdata <= prdata_next;
   end

////////////////////////////////////////////////////////////////////////
   // Assertions
   // Mode, strap and power
   a_mode_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      strap_taken_reg |=> $stable(mod_resume_reg))
      else $error("mode bit changed");
   a_mode_caught: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(strap_taken_reg) |-> mod_resume_reg == $past(cfg_mod_resume))
      else $error("mode bit not captured");
   a_strap_caught: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(strap_taken_reg) |-> strap_reg == $past(config_method_strap_bit1))
      else $error("strap not captured");
   a_strap_held: assert property (@(posedge pclk) disable iff (!presetn)
      strap_taken_reg |=> $stable(strap_reg) && config_method_sel == strap_reg)
      else $error("strap not held");
   a_led_polarity: assert property (@(posedge pclk) disable iff (!presetn)
      strap_taken_reg |=> speed_led_out == ($past(speed_level) ^ strap_reg))
      else $error("led polarity");
   a_led_level: assert property (@(posedge pclk) disable iff (!presetn)
      strap_taken_reg && !host_on |=> speed_led_out == strap_reg)
      else $error("led not negated");
   a_pullup_follows: assert property (@(posedge pclk) disable iff (!presetn)
      strap_taken_reg && host_on |=> dp_pullup_en)
      else $error("pull-up not asserted");
   a_pullup_drops: assert property (@(posedge pclk) disable iff (!presetn)
      !host_on |=> !dp_pullup_en)
      else $error("pull-up not negated");
   a_func_on: assert property (@(posedge pclk) disable iff (!presetn)
      strap_taken_reg && host_on |=> usb_func_en)
      else $error("function not enabled");
   a_func_off: assert property (@(posedge pclk) disable iff (!presetn)
      !host_on |=> !usb_func_en)
      else $error("function not disabled");
   a_ports_normal_on: assert property (@(posedge pclk) disable iff (!presetn)
      strap_taken_reg && !mod_resume_reg && host_on |=> &ds_port_power_en)
      else $error("ports off with power");
   a_mod_no_reset: assert property (@(posedge pclk) disable iff (!presetn)
      mod_resume_reg && strap_taken_reg |=> !hub_logic_reset && (&ds_port_power_en))
      else $error("modified mode reset hub");
   a_norm_reset: assert property (@(posedge pclk) disable iff (!presetn)
      strap_taken_reg && !mod_resume_reg && !host_on && !bc_en |=> hub_logic_reset && ds_port_power_en == '0)
      else $error("normal mode did not reset");

   // Wake sequence
   a_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(any_raw) && state_reg == ST_IDLE |=> state_reg == ST_IDLE)
      else $error("no filtering");
   a_filter_min: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && filt_cnt_reg != CNT_W'(FILTER_CYCLES) |=> state_reg == ST_IDLE)
      else $error("wake before filter");
   a_wake_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && !rw_en |=> state_reg == ST_IDLE)
      else $error("wake while disabled");
   a_pulse_starts: assert property (@(posedge pclk) disable iff (!presetn)
      wake_fire |=> wake_indicator)
      else $error("indicator not driven");
   a_pulse_held: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_PULSE && !pulse_len_end && !host_took_over |=> wake_indicator)
      else $error("indicator dropped early");
   a_pulse_ends: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_PULSE && pulse_len_end && !host_took_over |=> !wake_indicator && state_reg == ST_FINISH)
      else $error("indicator not ended");
   a_len_mod: assert property (@(posedge pclk) disable iff (!presetn)
      mod_resume_reg && state_reg == ST_PULSE && pulse_cnt_reg < CNT_W'(PULSE_CYCLES - 1) && !host_took_over
      |=> state_reg == ST_PULSE) else $error("fixed pulse cut short");
   a_len_normal: assert property (@(posedge pclk) disable iff (!presetn)
      !mod_resume_reg && state_reg == ST_PULSE && pulse_cnt_reg + CNT_W'(1) < resume_time_reg && !host_took_over
      |=> state_reg == ST_PULSE) else $error("resume pulse cut short");
   a_finish_idle: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_FINISH |=> state_reg == ST_IDLE)
      else $error("finish not left");
   a_eop_once: assert property (@(posedge pclk) disable iff (!presetn)
      ds_eop_request |=> !ds_eop_request)
      else $error("eop repeated");
   a_finish_eop: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_FINISH && mod_resume_reg |=> ds_eop_request)
      else $error("eop missing");
   a_no_eop_normal: assert property (@(posedge pclk) disable iff (!presetn)
      strap_taken_reg && !mod_resume_reg |=> !ds_eop_request)
      else $error("eop in normal mode");
   a_takeover_idle: assert property (@(posedge pclk) disable iff (!presetn)
      host_took_over |=> state_reg == ST_IDLE)
      else $error("host K ignored");

   // Link outputs
   a_resume_sel: assert property (@(posedge pclk) disable iff (!presetn)
      mod_resume_reg && state_reg == ST_PULSE && !host_took_over |=> ds_resume_drive == $past(wake_ports_reg))
      else $error("resume on wrong ports");
   a_takeover_ports: assert property (@(posedge pclk) disable iff (!presetn)
      host_took_over |=> ds_resume_drive == ~$past(wake_ports_reg))
      else $error("other ports not resumed");
   a_no_k_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_PULSE |=> !upstream_k_drive)
      else $error("K upstream during pulse");
   a_k_follows: assert property (@(posedge pclk) disable iff (!presetn)
      strap_taken_reg && host_on && proto_k_request && state_reg == ST_IDLE |=> upstream_k_drive)
      else $error("K not driven");
   a_k_needs_power: assert property (@(posedge pclk) disable iff (!presetn)
      !host_on |=> !upstream_k_drive)
      else $error("K into unpowered host");
   a_suspend_shown: assert property (@(posedge pclk) disable iff (!presetn)
      suspended && state_reg == ST_IDLE && !wake_fire |=> wake_indicator)
      else $error("suspend not shown");
   a_active_shown: assert property (@(posedge pclk) disable iff (!presetn)
      !suspended && state_reg == ST_IDLE && !wake_fire |=> !wake_indicator)
      else $error("active not shown");

   c_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_fire);
   c_normal_pulse: cover property (@(posedge pclk) disable iff (!presetn) wake_fire && !mod_resume_reg);
   c_host_k: cover property (@(posedge pclk) disable iff (!presetn) host_took_over);
   c_timeout: cover property (@(posedge pclk) disable iff (!presetn) ds_eop_request);
   c_hs_led: cover property (@(posedge pclk) disable iff (!presetn) speed_level);
endmodule : hrw_wake_indicator

//--- test/hrw_host_model.sv
// Purpose: Upstream host with switchable bus power
// Assumes: Bench sets the power and reply controls on pclk edges
// Notes: With reply off the host never answers, so the wake window lapses
`timescale 1ns/10ps
module hrw_host_model
#(
   parameter int unsigned DELAY = 20
)
(
   // Clock
   input wire logic pclk,
   // Bench controls
   input wire logic power_on,
   input wire logic answer_en,
   // Hub side
   input wire logic wake_indicator,
   output logic host_power_sense,
   output logic host_k_detect
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] wait_reg;
   logic answer;
   // Host counts from the indicator, then restores power and sends K together
   always_ff @(posedge pclk)
   begin
      if (!answer_en)
         wait_reg <= 8'h00;
      else if (wake_indicator && !answer)
         wait_reg <= wait_reg + 8'h01;
   end
   assign answer = answer_en && (wait_reg == 8'(DELAY));
   assign host_power_sense = power_on || answer;
   assign host_k_detect = answer;
endmodule : hrw_host_model

//--- test/tb_hub_remote_wake_indicator.sv
// Purpose: Self-checking bench for the hub wake indicator
// Assumes: Short filter and pulse counts set through parameters
// Notes: Drives at rising edges, samples at falling edges; the APB task samples pready, pslverr and prdata at rising edges
`timescale 1ns/10ps
module tb_hub_remote_wake_indicator
   import hrw_pkg::*;
();
   localparam int FILT = 8;
   localparam int PULS = 50;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic cfg_mod_resume, strap, hps, hkd, proto_k_request, power_on, answer_en;
   logic dp_pullup_en, upstream_k_drive, usb_func_en, hub_logic_reset, wake_indicator;
   logic [2:0] ev [3];
   logic [2:0] ds_port_power_en, ds_resume_drive, rs, m;
   logic ds_eop_request, config_method_sel, speed_led_out, speed_led_oe, uk, eop, rr;
   int n_mismatch, compares, len, p, rt;
   ////////////////////////////////////////////////////////////////////////////
   hrw_wake_indicator #(.PORTS(3), .FILTER_CYCLES(FILT), .PULSE_CYCLES(PULS)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_mod_resume(cfg_mod_resume),
      .config_method_strap_bit1(strap), .host_power_sense(hps), .host_k_detect(hkd),
      .proto_k_request(proto_k_request), .dp_pullup_en(dp_pullup_en), .upstream_k_drive(upstream_k_drive),
      .usb_func_en(usb_func_en), .hub_logic_reset(hub_logic_reset), .wake_indicator(wake_indicator),
      .ds_connect_evt(ev[0]), .ds_disconnect_evt(ev[1]), .ds_wake_req(ev[2]),
      .ds_port_power_en(ds_port_power_en), .ds_resume_drive(ds_resume_drive), .ds_eop_request(ds_eop_request),
      .config_method_sel(config_method_sel), .speed_led_out(speed_led_out), .speed_led_oe(speed_led_oe));
   hrw_host_model #(.DELAY(20)) host (.pclk(pclk), .power_on(power_on), .answer_en(answer_en),
      .wake_indicator(wake_indicator), .host_power_sense(hps), .host_k_detect(hkd));
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
   begin
      if (n_mismatch == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
   begin
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   end
   endtask : chk
   task automatic settle(input int n);
   begin
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   end
   endtask : settle
   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
      int i;
   begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      q = prdata;
      chk("pready", 1, pready);
      chk("pslverr", 32'(er), pslverr);
      {psel, penable} <= 2'b00;
   end
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e, input logic er);
   begin
      apb(1'b0, a, 32'h0, er);
      chk("prdata", e, q & mk);
   end
   endtask : rd
   task automatic rst;
   begin
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      settle(2);
   end
   endtask : rst
   // Event of kind k on port p, then the indicator pulse is measured
   task automatic wake(input int k);
      int i;
   begin
      p = $urandom_range(0, 2);
      m = 3'b001 << p;
      @(posedge pclk);
      ev[k][p] <= 1'b1;
      repeat (FILT + 1) @(posedge pclk);
      ev[k][p] <= 1'b0;
      {len, i, rs, uk, eop, rr} = '0;
      while (i < 400 && !(len > 0 && wake_indicator === 1'b0))
      begin
         @(negedge pclk);
         i++;
         len += int'(wake_indicator === 1'b1);
         {rs, uk, eop} = {rs | ds_resume_drive, uk | upstream_k_drive, eop | ds_eop_request};
      end
      if (i >= 400)
      begin
         n_mismatch++;
         test_done();
      end
      else
         repeat (20)
         begin
            @(negedge pclk);
            {eop, rr} = {eop | ds_eop_request, rr | wake_indicator};
         end
   end
   endtask : wake
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {n_mismatch, compares} = '0;
      void'($urandom(32'h03FE));
      {presetn, psel, penable, pwrite, proto_k_request, power_on, answer_en} = 7'h00;
      {paddr, pwdata, ev[0], ev[1], ev[2]} = '0;
      {cfg_mod_resume, strap} = 2'b11;
      rst();
      rd(ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RESET, 1'b0);
      rd(ADDR_RESUME_TIME, 32'hFFFF_FFFF, {8'h00, RESUME_TIME_RESET}, 1'b0);
      rd(8'h10 + 8'h04 * 8'($urandom_range(0, 59)), 32'hFFFF_FFFF, UNMAPPED_READ, 1'b1);
      rd(ADDR_STATUS, 32'h0C, 32'h0C, 1'b0);
      @(posedge pclk);
      power_on <= 1'b1;
      settle(2);
      chk("dp_pullup_en", 1, dp_pullup_en);
      chk("usb_func_en", 1, usb_func_en);
      apb(1'b1, ADDR_CTRL, 32'h12, 1'b0);
      settle(2);
      chk("speed_led_out", 0, speed_led_out);
      chk("speed_led_oe", 1, speed_led_oe);
      apb(1'b1, ADDR_CTRL, 32'h02, 1'b0);
      settle(2);
      chk("speed_led_out", 1, speed_led_out);
      @(posedge pclk);
      {strap, cfg_mod_resume, power_on} <= 3'b000;
      settle(3);
      chk("config_method_sel", 1, config_method_sel);
      chk("dp_pullup_en", 0, dp_pullup_en);
      chk("hub_logic_reset", 0, hub_logic_reset);
      chk("ds_port_power_en", 7, ds_port_power_en);
      rd(ADDR_STATUS, 32'h04, 32'h04, 1'b0);
      @(posedge pclk);
      ev[0][1] <= 1'b1;
      repeat (FILT - 1) @(posedge pclk);
      ev[0][1] <= 1'b0;
      settle(12);
      chk("wake_indicator", 0, wake_indicator);
      for (int k = 0; k < 3; k++)
      begin
         wake(k);
         chk("pulse_len", PULS, len);
         chk("upstream_k_drive", 0, uk);
         chk("resume_ports", 0, rs & ~m);
         chk("ds_eop_request", 1, eop);
         chk("re_rise", 0, rr);
      end
      @(posedge pclk);
      answer_en <= 1'b1;
      wake(2);
      chk("short_pulse", 1, len < PULS);
      chk("other_ports", 7, rs);
      @(posedge pclk);
      {answer_en, power_on} <= 2'b01;
      rst();
      rt = $urandom_range(20, 60);
      apb(1'b1, ADDR_RESUME_TIME, rt, 1'b0);
      apb(1'b1, ADDR_CTRL, 32'h12, 1'b0);
      settle(2);
      chk("speed_led_out", 1, speed_led_out);
      @(posedge pclk);
      proto_k_request <= 1'b1;
      settle(2);
      chk("upstream_k_drive", 1, upstream_k_drive);
      @(posedge pclk);
      proto_k_request <= 1'b0;
      wake(1);
      chk("pulse_len", rt, len);
      apb(1'b1, ADDR_CTRL, 32'h1A, 1'b0);
      settle(2);
      chk("wake_indicator", 1, wake_indicator);
      apb(1'b1, ADDR_CTRL, 32'h12, 1'b0);
      @(posedge pclk);
      power_on <= 1'b0;
      settle(3);
      chk("dp_pullup_en", 0, dp_pullup_en);
      chk("hub_logic_reset", 1, hub_logic_reset);
      chk("ds_port_power_en", 0, ds_port_power_en);
      test_done();
   end
endmodule : tb_hub_remote_wake_indicator
